/* include/dcc_map.svh */
// Register offsets, field positions and reset values of the comparator control block.
// Assumes a 32-bit AXI4-Lite register window; each register is one aligned word.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_OFF_CTRL 8'h00
`define DCC_OFF_FLAGS 8'h04
`define DCC_OFF_ENABLES 8'h08
`define DCC_OFF_INTCTL 8'h0C
`define DCC_OFF_DIR 8'h10
`define DCC_OFF_PORT 8'h14
`define DCC_OFF_LATCH 8'h18
`define DCC_BIT_TWO_RESULT 7
`define DCC_BIT_ONE_RESULT 6
`define DCC_BIT_TWO_INVERT 5
`define DCC_BIT_ONE_INVERT 4
`define DCC_BIT_INPUT_SWITCH 3
`define DCC_BIT_CHANGE_FLAG 6
`define DCC_BIT_CMP_IRQ_EN 6
`define DCC_BIT_PER_IRQ_EN 6
`define DCC_BIT_GLB_IRQ_EN 7
`define DCC_CTRL_RESET 6'h07
`define DCC_DIR_RESET 6'h3F
`define DCC_MODE_MUX4 3'h6
`define DCC_MODE_OFF 3'h7
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2
`endif

/* include/dcc_pkg.sv */
// Types shared by the comparator control block.
// Assumes dcc_map.svh for all numeric constants.
`default_nettype none
package dcc_pkg;
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [5:0] ctrl;
        logic [1:0] latched;
        logic flag;
        logic cmp_ie;
        logic per_ie;
        logic glb_ie;
        logic [5:0] dir;
        logic [5:0] port_latch;
        logic irq;
        logic wake;
        logic vref;
        logic pair_high;
        logic [1:0] cmp_en;
    } dcc_state_s;
endpackage
`default_nettype wire

/* include/dcc_sync_if.sv */
// Carrier between the top module and its input synchroniser.
// Assumes the synchroniser and its user share one clock.
`timescale 1ns/1ps
`default_nettype none
interface dcc_sync_if #(parameter int W = 8);
    logic [W-1:0] async_in;
    logic [W-1:0] sync_out;
    modport user (output async_in, input sync_out);
    modport sync (input async_in, output sync_out);
endinterface
`default_nettype wire

/* hw/dcc_sync.sv */
// Two-stage synchroniser for asynchronous levels.
// Assumes levels change slowly against the clock; no pulse capture.
`timescale 1ns/1ps
`default_nettype none
module dcc_sync #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    dcc_sync_if.sync bus
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } dcc_sync_state_s;

    dcc_sync_state_s s_reg;
    dcc_sync_state_s s_next;

    // First stage feeds only the second stage
    always_comb begin
        s_next = s_reg;
        s_next.first = bus.async_in;
        s_next.second = s_reg.first;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.sync_out = s_reg.second;
endmodule // dcc_sync
`default_nettype wire

/* hw/dcc_top.sv */
// Control and status logic around two analog comparators, AXI4-Lite register slave.
// Assumes raw comparator outputs and port pins are asynchronous; analog-pin map is same-clock.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_map.svh"
module dcc_top import dcc_pkg::*; #(
    // Two bits per mode, bit 0 comparator one, bit 1 comparator two
    parameter logic [15:0] MODE_CMP_ON = 16'h3FFF,
    // One bit per mode: comparator outputs routed to pins four and five
    parameter logic [7:0] MODE_PIN_OUT = 8'h00
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_S_AXI_AWVALID,
    output logic O_S_AXI_AWREADY,
    input wire logic [7:0] I_S_AXI_AWADDR,
    input wire logic I_S_AXI_WVALID,
    output logic O_S_AXI_WREADY,
    input wire logic [31:0] I_S_AXI_WDATA,
    input wire logic [3:0] I_S_AXI_WSTRB,
    output logic O_S_AXI_BVALID,
    input wire logic I_S_AXI_BREADY,
    output logic [1:0] O_S_AXI_BRESP,
    input wire logic I_S_AXI_ARVALID,
    output logic O_S_AXI_ARREADY,
    input wire logic [7:0] I_S_AXI_ARADDR,
    output logic O_S_AXI_RVALID,
    input wire logic I_S_AXI_RREADY,
    output logic [31:0] O_S_AXI_RDATA,
    output logic [1:0] O_S_AXI_RRESP,
    input wire logic [1:0] I_CMP_RAW,
    input wire logic [5:0] I_PORT_A_PIN,
    input wire logic [5:0] I_ANALOG_CFG,
    input wire logic I_SLEEP,
    output logic O_IRQ,
    output logic O_WAKE,
    output logic [1:0] O_CMP_ENABLE,
    output logic O_VREF_SEL,
    output logic O_PAIR_HIGH,
    output logic [5:0] O_PORT_A_OUT,
    output logic [5:0] O_PORT_A_OE_N
);
    dcc_state_s s_reg;
    dcc_state_s s_next;

    dcc_sync_if #(.W(8)) sync_bus ();
    logic [1:0] cmp_sync;
    logic [5:0] pin_sync;
    logic [1:0] invert;
    logic [2:0] mode;
    logic [1:0] active;
    logic [1:0] result_cur;
    logic mismatch;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    logic wr_en;
    logic ar_ok;
    logic ctrl_access;
    logic [5:0] ctrl_n;
    logic [7:0] rd_val;

    assign sync_bus.async_in = {I_PORT_A_PIN, I_CMP_RAW};

    dcc_sync #(.W(8)) u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .bus(sync_bus.sync)
    );

    assign cmp_sync = sync_bus.sync_out[1:0];
    assign pin_sync = sync_bus.sync_out[7:2];
    assign invert = {s_reg.ctrl[`DCC_BIT_TWO_INVERT], s_reg.ctrl[`DCC_BIT_ONE_INVERT]};
    assign mode = s_reg.ctrl[2:0];
    assign active = MODE_CMP_ON[{mode, 1'b0} +: 2];
    // Inactive comparators read low; polarity follows the invert bits
    assign result_cur = active & (cmp_sync ^ invert);
    assign mismatch = result_cur != s_reg.latched;

    assign aw_hs = I_S_AXI_AWVALID && s_reg.awready;
    assign w_hs = I_S_AXI_WVALID && s_reg.wready;
    assign ar_hs = I_S_AXI_ARVALID && s_reg.arready;
    assign wr_go = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    assign wr_en = wr_go && s_reg.wstrb0;
    assign ctrl_access = (wr_go && s_reg.aw_addr == `DCC_OFF_CTRL)
        || (ar_hs && I_S_AXI_ARADDR == `DCC_OFF_CTRL);

    always_comb begin
        ar_ok = 1'b1;
        case (I_S_AXI_ARADDR)
            `DCC_OFF_CTRL: rd_val = {result_cur, s_reg.ctrl};
            `DCC_OFF_FLAGS: rd_val = {1'b0, s_reg.flag, 6'h00};
            `DCC_OFF_ENABLES: rd_val = {1'b0, s_reg.cmp_ie, 6'h00};
            `DCC_OFF_INTCTL: rd_val = {s_reg.glb_ie, s_reg.per_ie, 6'h00};
            `DCC_OFF_DIR: rd_val = {2'h0, s_reg.dir};
            `DCC_OFF_PORT: rd_val = {2'h0, pin_sync & ~I_ANALOG_CFG};
            `DCC_OFF_LATCH: rd_val = {2'h0, s_reg.port_latch};
            default: begin
                rd_val = 8'h00;
                ar_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_next = s_reg;
        ctrl_n = s_reg.ctrl;
        // Write channel: address and data taken in either order
        if (aw_hs) begin
            s_next.awready = 1'b0;
            s_next.aw_held = 1'b1;
            s_next.aw_addr = I_S_AXI_AWADDR;
        end
        if (w_hs) begin
            s_next.wready = 1'b0;
            s_next.w_held = 1'b1;
            s_next.wdata = I_S_AXI_WDATA[7:0];
            s_next.wstrb0 = I_S_AXI_WSTRB[0];
        end
        if (wr_go) begin
            s_next.bvalid = 1'b1;
            s_next.bresp = `DCC_RESP_OKAY;
            case (s_reg.aw_addr)
                `DCC_OFF_CTRL: begin
                    // Result bits are never stored, so writes to them vanish
                    if (s_reg.wstrb0) begin
                        ctrl_n = s_reg.wdata[5:0];
                    end
                end
                `DCC_OFF_FLAGS, `DCC_OFF_ENABLES, `DCC_OFF_INTCTL, `DCC_OFF_PORT: begin
                end
                `DCC_OFF_DIR: begin
                    if (s_reg.wstrb0) begin
                        s_next.dir = s_reg.wdata[5:0];
                    end
                end
                `DCC_OFF_LATCH: begin
                    if (s_reg.wstrb0) begin
                        s_next.port_latch = s_reg.wdata[5:0];
                    end
                end
                default: s_next.bresp = `DCC_RESP_SLVERR;
            endcase
            if (wr_en && s_reg.aw_addr == `DCC_OFF_FLAGS) begin
                s_next.flag = s_reg.wdata[`DCC_BIT_CHANGE_FLAG];
            end
            if (wr_en && s_reg.aw_addr == `DCC_OFF_ENABLES) begin
                s_next.cmp_ie = s_reg.wdata[`DCC_BIT_CMP_IRQ_EN];
            end
            if (wr_en && s_reg.aw_addr == `DCC_OFF_INTCTL) begin
                s_next.glb_ie = s_reg.wdata[`DCC_BIT_GLB_IRQ_EN];
                s_next.per_ie = s_reg.wdata[`DCC_BIT_PER_IRQ_EN];
            end
        end
        if (s_reg.bvalid && I_S_AXI_BREADY) begin
            s_next.bvalid = 1'b0;
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        // Read channel: one word in flight, answer one cycle after the address
        if (ar_hs) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_val;
            s_next.rresp = ar_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
        end
        if (s_reg.rvalid && I_S_AXI_RREADY) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // Access re-latches; the mismatch then ends on the next cycle
        if (ctrl_access) begin
            s_next.latched = result_cur;
        end
        // Mismatch outranks a software clear in the same cycle
        if (mismatch) begin
            s_next.flag = 1'b1;
        end
        // Sleep has no path into the control register
        s_next.ctrl = ctrl_n;
        s_next.irq = s_next.flag && s_next.cmp_ie && s_next.per_ie && s_next.glb_ie;
        s_next.wake = I_SLEEP && s_next.flag && s_next.cmp_ie && s_next.per_ie;
        s_next.vref = ctrl_n[2:0] == `DCC_MODE_MUX4;
        s_next.pair_high = s_next.vref && ctrl_n[`DCC_BIT_INPUT_SWITCH];
        s_next.cmp_en = MODE_CMP_ON[{ctrl_n[2:0], 1'b0} +: 2];
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            s_reg <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.ctrl <= `DCC_CTRL_RESET;
            s_reg.dir <= `DCC_DIR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign O_S_AXI_AWREADY = s_reg.awready;
    assign O_S_AXI_WREADY = s_reg.wready;
    assign O_S_AXI_BVALID = s_reg.bvalid;
    assign O_S_AXI_BRESP = s_reg.bresp;
    assign O_S_AXI_ARREADY = s_reg.arready;
    assign O_S_AXI_RVALID = s_reg.rvalid;
    assign O_S_AXI_RDATA = {24'h000000, s_reg.rdata};
    assign O_S_AXI_RRESP = s_reg.rresp;
    assign O_IRQ = s_reg.irq;
    assign O_WAKE = s_reg.wake;
    assign O_CMP_ENABLE = s_reg.cmp_en;
    assign O_VREF_SEL = s_reg.vref;
    assign O_PAIR_HIGH = s_reg.pair_high;
    assign O_PORT_A_OE_N = s_reg.dir;
    // Routed pins bypass the flops on purpose: the output must not wait for a clock
    assign O_PORT_A_OUT[3:0] = s_reg.port_latch[3:0];
    assign O_PORT_A_OUT[4] = MODE_PIN_OUT[mode] ? (I_CMP_RAW[0] ^ invert[0])
        : s_reg.port_latch[4];
    assign O_PORT_A_OUT[5] = MODE_PIN_OUT[mode] ? (I_CMP_RAW[1] ^ invert[1])
        : s_reg.port_latch[5];

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    property p_result_read;
        ar_hs && I_S_AXI_ARADDR == `DCC_OFF_CTRL |=> O_S_AXI_RDATA[7:6] == $past(result_cur);
    endproperty
    a_result_read: assert property (p_result_read) else $error("result bits misread");

    property p_ctrl_only_by_write;
        !(wr_go && s_reg.aw_addr == `DCC_OFF_CTRL) |=> s_reg.ctrl == $past(s_reg.ctrl);
    endproperty
    a_ctrl_only_by_write: assert property (p_ctrl_only_by_write) else $error("ctrl changed");

    property p_mismatch_sets;
        mismatch |=> s_reg.flag;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) else $error("flag not set");

    property p_relatch;
        ctrl_access |=> s_reg.latched == $past(result_cur);
    endproperty
    a_relatch: assert property (p_relatch) else $error("no re-latch");

    property p_clear_needs_match;
        $fell(s_reg.flag) |-> !$past(mismatch);
    endproperty
    a_clear_needs_match: assert property (p_clear_needs_match) else $error("flag lost");

    property p_soft_set;
        wr_en && s_reg.aw_addr == `DCC_OFF_FLAGS && s_reg.wdata[`DCC_BIT_CHANGE_FLAG]
            |=> s_reg.flag;
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("software set lost");

    property p_irq_gate;
        O_IRQ |-> s_reg.flag && s_reg.cmp_ie && s_reg.per_ie && s_reg.glb_ie;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

    // Reference select tracks the stored mode in every cycle, not only on a rise
    property p_vref_mode;
        O_VREF_SEL == (mode == `DCC_MODE_MUX4);
    endproperty
    a_vref_mode: assert property (p_vref_mode) else $error("reference outside mode");

    property p_pair_in_mux4;
        O_PAIR_HIGH |-> O_VREF_SEL && s_reg.ctrl[`DCC_BIT_INPUT_SWITCH];
    endproperty
    a_pair_in_mux4: assert property (p_pair_in_mux4) else $error("pair switch misused");

    property p_wake;
        O_WAKE |-> $past(I_SLEEP) && s_reg.flag;
    endproperty
    a_wake: assert property (p_wake) else $error("spurious wake");

    c_flag_set: cover property (mismatch ##1 s_reg.flag);
    c_ctrl_read: cover property (ar_hs && I_S_AXI_ARADDR == `DCC_OFF_CTRL ##1 O_S_AXI_RVALID);
    c_irq: cover property ($rose(O_IRQ));
    c_mux4: cover property ($rose(O_PAIR_HIGH));
endmodule // dcc_top
`default_nettype wire

/* dv/dcc_partner.sv */
// Far-side model: comparator analog outputs and the outside of port A pins.
// Assumes the bench sets which comparator sees plus above minus.
`timescale 1ns/1ps
`default_nettype none
module dcc_partner (
    input wire logic [1:0] i_cmp_gt,
    input wire logic [5:0] i_ext_pins,
    input wire logic [5:0] i_pin_out,
    input wire logic [5:0] i_pin_oe_n,
    output logic [1:0] o_cmp_raw,
    output logic [5:0] o_pin_level
);
    // High when plus input sits above minus input
    assign o_cmp_raw = i_cmp_gt;
    // Driven pins carry the block's level, released pins the outside source
    assign o_pin_level = (i_pin_out & ~i_pin_oe_n) | (i_ext_pins & i_pin_oe_n);
endmodule // dcc_partner
`default_nettype wire

/* dv/dcc_top_tb_top.sv */
// Self-checking bench for the comparator control block.
// Assumes pin routing enabled in mode 011 only and the default activity table.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_map.svh"
module dcc_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, slp = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] gt = 2'b00;
    logic [5:0] ext = 6'h2A, acfg = 6'h00;
    logic awr, wrdy, bv, arr, rv, irq, wake, vref, pair;
    logic [1:0] brsp, rrsp, raw, cen, rsp;
    logic [5:0] pout, poe, plvl;
    int mismatches = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    dcc_top #(.MODE_PIN_OUT(8'h08)) i_dcc_top (.I_CORE_CLK(clk), .I_RST(rst),
        .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr), .I_S_AXI_AWADDR(awa),
        .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wrdy), .I_S_AXI_WDATA(wd), .I_S_AXI_WSTRB(4'hF),
        .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(bry), .O_S_AXI_BRESP(brsp),
        .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr), .I_S_AXI_ARADDR(ara),
        .O_S_AXI_RVALID(rv), .I_S_AXI_RREADY(rry), .O_S_AXI_RDATA(rdat), .O_S_AXI_RRESP(rrsp),
        .I_CMP_RAW(raw), .I_PORT_A_PIN(plvl), .I_ANALOG_CFG(acfg), .I_SLEEP(slp),
        .O_IRQ(irq), .O_WAKE(wake), .O_CMP_ENABLE(cen), .O_VREF_SEL(vref),
        .O_PAIR_HIGH(pair), .O_PORT_A_OUT(pout), .O_PORT_A_OE_N(poe));
    dcc_partner i_dcc_partner (.i_cmp_gt(gt), .i_ext_pins(ext), .i_pin_out(pout),
        .i_pin_oe_n(poe), .o_cmp_raw(raw), .o_pin_level(plvl));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        $display("[FAIL] bus answer expected within bound seen none");
        complete_run();
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bit got;
        got = 0;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv && bry) begin
                got = 1;
                rsp = brsp;
                bry <= 1'b0;
            end
        end
        if (!got) hang();
    endtask
    task automatic rd(input logic [7:0] a);
        bit got;
        got = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv && rry) begin
                got = 1;
                d = rdat;
                rsp = rrsp;
                rry <= 1'b0;
            end
        end
        if (!got) hang();
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, d, e);
    endtask
    task automatic t_reset();
        rchk(`DCC_OFF_CTRL, 32'h07, "ctrl reset");
        rchk(`DCC_OFF_DIR, 32'h3F, "dir reset");
        chk("cmp enable reset", cen, 2'b00);
        rchk(8'h1C, 32'h0, "unmapped data");
        chk("unmapped resp", rsp, `DCC_RESP_SLVERR);
        wr(8'h1C, 8'hFF);
        chk("unmapped write resp", rsp, `DCC_RESP_SLVERR);
    endtask
    task automatic t_result();
        @(posedge clk);
        gt <= 2'b01;
        wr(`DCC_OFF_CTRL, 8'hC0);
        chk("write resp", rsp, `DCC_RESP_OKAY);
        settle(4);
        rchk(`DCC_OFF_CTRL, 32'h40, "result plain");
        wr(`DCC_OFF_CTRL, 8'h30);
        settle(4);
        rchk(`DCC_OFF_CTRL, 32'hB0, "result inverted");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            wr(`DCC_OFF_CTRL, 8'h08 | 8'(m));
            chk("mode activity", cen, (m == 7) ? 2'b00 : 2'b11);
            chk("reference select", vref, m == 6);
            chk("upper pair", pair, m == 6);
        end
        wr(`DCC_OFF_CTRL, 8'h06);
        chk("lower pair", pair, 1'b0);
    endtask
    task automatic t_irq();
        @(posedge clk);
        gt <= 2'b00;
        // Mode change while comparator interrupts are still off
        wr(`DCC_OFF_CTRL, 8'h00);
        settle(4);
        rd(`DCC_OFF_CTRL);
        wr(`DCC_OFF_ENABLES, 8'h40);
        wr(`DCC_OFF_INTCTL, 8'hC0);
        wr(`DCC_OFF_FLAGS, 8'h00);
        rchk(`DCC_OFF_FLAGS, 32'h00, "flag idle");
        gt <= 2'b10;
        settle(6);
        rchk(`DCC_OFF_FLAGS, 32'h40, "flag on change");
        chk("irq all enabled", irq, 1'b1);
        wr(`DCC_OFF_FLAGS, 8'h00);
        rchk(`DCC_OFF_FLAGS, 32'h40, "flag held by mismatch");
        rchk(`DCC_OFF_CTRL, 32'h80, "ctrl relatch read");
        wr(`DCC_OFF_FLAGS, 8'h00);
        rchk(`DCC_OFF_FLAGS, 32'h00, "flag cleared");
        chk("irq cleared", irq, 1'b0);
        wr(`DCC_OFF_FLAGS, 8'h40);
        rchk(`DCC_OFF_FLAGS, 32'h40, "flag written");
        chk("irq simulated", irq, 1'b1);
        wr(`DCC_OFF_INTCTL, 8'h40);
        chk("irq global off", irq, 1'b0);
        wr(`DCC_OFF_FLAGS, 8'h00);
        @(posedge clk);
        slp <= 1'b1;
        gt <= 2'b00;
        settle(6);
        chk("wake", wake, 1'b1);
        rchk(`DCC_OFF_FLAGS, 32'h40, "flag without global");
        rchk(`DCC_OFF_CTRL, 32'h00, "ctrl after wake");
        slp <= 1'b0;
    endtask
    task automatic t_pins();
        wr(`DCC_OFF_ENABLES, 8'h00);
        wr(`DCC_OFF_DIR, 8'h0F);
        chk("pin enables", poe, 6'h0F);
        wr(`DCC_OFF_LATCH, 8'h05);
        @(posedge clk);
        gt <= 2'b01;
        wr(`DCC_OFF_CTRL, 8'h13);
        chk("routed pins", pout, 6'h05);
        @(posedge clk);
        gt <= 2'b10;
        acfg <= 6'h03;
        #1;
        // Before the next clock edge: no clock in the path
        chk("routed pins unsynced", pout, 6'h35);
        settle(4);
        rchk(`DCC_OFF_PORT, 32'h38, "port read analog");
        wr(`DCC_OFF_DIR, 8'h3F);
        settle(4);
        rchk(`DCC_OFF_PORT, 32'h28, "port released");
    endtask
    task automatic t_rerst();
        @(posedge clk);
        rst <= 1'b1;
        settle(2);
        rst <= 1'b0;
        rchk(`DCC_OFF_CTRL, 32'h07, "ctrl reset mid-run");
        chk("cmp enable mid-run reset", cen, 2'b00);
        chk("pin enables mid-run reset", poe, 6'h3F);
    endtask
    initial begin
        settle(8);
        rst <= 1'b0;
        t_reset();
        t_result();
        t_modes();
        t_irq();
        t_pins();
        t_rerst();
        complete_run();
    end
endmodule // dcc_top_tb_top
`default_nettype wire
